// ===== verilog/prv_map.svh
`ifndef PRV_MAP_SVH
`define PRV_MAP_SVH

// ----------------------------------------------------------------------------
// Management word view
// ----------------------------------------------------------------------------
`define PRV_REG_ID_UPPER 5'h02
`define PRV_REG_ID_LOWER 5'h03
`define PRV_REG_ADVERT 5'h04
`define PRV_REG_PARTNER 5'h05
`define PRV_REG_LAST 5'h05
`define PRV_PHY_ADDRESS_FIRST 5'h01
`define PRV_PHY_ADDRESS_SECOND 5'h02
`define PRV_SELECTOR 5'h01
`define PRV_ADV_PAUSE_BIT 10
`define PRV_ADV_LOW_BIT 5

// ----------------------------------------------------------------------------
// Byte register space
// ----------------------------------------------------------------------------
`define PRV_PORT_FIRST_HI 4'h1
`define PRV_PORT_LAST_HI 4'h3
`define PRV_CTRL_BYTES 14
`define PRV_CTRL_LAST_IDX 4'hd
`define PRV_STATUS_LO_IDX 4'he
`define PRV_ADV_IDX 4'hc
`define PRV_ADV_RST 5'h1f
`define PRV_ADDR_PHY_ADDRESS 8'h40
`define PRV_PHY_ADDRESS_RST 8'h01

`endif

// ===== verilog/prv_pkg.sv
package prv_pkg;

	// Management word request
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] phy_address;
		logic [4:0] register_number;
		logic [15:0] wdata;
	} prv_mgmt_req_s;

	// Byte register request
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} prv_byte_req_s;

	typedef logic [2:0][15:0] prv_status_t;
	typedef logic [1:0][4:0] prv_adv_t;

endpackage : prv_pkg

// ===== verilog/prv_port_bank.sv
`timescale 1ns/1ns
`include "prv_map.svh"

module prv_port_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte side write
	input wire logic byte_we,
	input wire logic [3:0] byte_idx,
	input wire logic [7:0] byte_wdata,
	// Advertisement write from the word view
	input wire logic adv_we,
	input wire logic [4:0] adv_wdata,
	// Negotiation status
	input wire logic [15:0] status_in,
	// Read side
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_byte,
	output logic [4:0] adv,
	output logic [4:0] partner
);
	import prv_pkg::*;

	logic [7:0] ctrl [`PRV_CTRL_BYTES];
	logic [15:0] status;

	// ------------------------------------------------------------------------
	// Control bytes
	// ------------------------------------------------------------------------
	// shared pause storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `PRV_CTRL_BYTES; i++) begin
				ctrl[i] <= 8'h00;
			end
			ctrl[`PRV_ADV_IDX] <= {3'h0, `PRV_ADV_RST};
		end else begin
			if (byte_we && byte_idx <= `PRV_CTRL_LAST_IDX) begin
				ctrl[byte_idx] <= byte_wdata;
			end
			// Word-view write wins the shared bits on a collision
			if (adv_we) begin
				ctrl[`PRV_ADV_IDX][4:0] <= adv_wdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Status bytes
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= 16'h0000;
		end else begin
			status <= status_in;
		end
	end

	always_comb begin
		if (rd_idx <= `PRV_CTRL_LAST_IDX) begin
			rd_byte = ctrl[rd_idx];
		end else if (rd_idx == `PRV_STATUS_LO_IDX) begin
			rd_byte = status[7:0];
		end else begin
			rd_byte = status[15:8];
		end
	end

	assign adv = ctrl[`PRV_ADV_IDX][4:0];
	assign partner = status[4:0];

endmodule : prv_port_bank

// ===== verilog/prv_phy_reg_view.sv
`timescale 1ns/1ns
`include "prv_map.svh"

module prv_phy_reg_view #(
	// Arbitrary identifier values
	parameter logic [15:0] ID_UPPER = 16'h0a5a,
	parameter logic [15:0] ID_LOWER = 16'h5a50
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Management word access
	input prv_pkg::prv_mgmt_req_s mgmt_req,
	output logic mgmt_ack,
	output logic [15:0] mgmt_rdata,
	// Byte register access
	input prv_pkg::prv_byte_req_s byte_req,
	output logic byte_ack,
	output logic [7:0] byte_rdata,
	// Mode and negotiation
	input wire logic center_mode,
	input prv_pkg::prv_status_t port_status,
	output prv_pkg::prv_adv_t adv_flags
);
	import prv_pkg::*;

	logic [7:0] phy_address_reg;
	logic [4:0] adv [3];
	logic [4:0] partner [3];
	logic [7:0] rd_byte [3];
	logic [2:0] bank_we;
	logic [1:0] adv_we;
	logic phy_match;
	logic phy_sel;
	logic mgmt_hit;
	logic [15:0] next_mgmt_rdata;
	logic [7:0] next_byte_rdata;
	logic [3:0] port_hi;
	logic [3:0] port_idx;

	// ------------------------------------------------------------------------
	// Management address decode
	// ------------------------------------------------------------------------
	// fixed PHY addresses 1 and 2 outside center mode; center mode matches phy_address_reg
	always_comb begin
		phy_sel = 1'b0;
		phy_match = 1'b0;
		if (center_mode) begin
			phy_match = mgmt_req.phy_address == phy_address_reg[4:0];
		end else if (mgmt_req.phy_address == `PRV_PHY_ADDRESS_FIRST) begin
			phy_match = 1'b1;
		end else if (mgmt_req.phy_address == `PRV_PHY_ADDRESS_SECOND) begin
			phy_match = 1'b1;
			phy_sel = 1'b1;
		end
	end

	assign mgmt_hit = mgmt_req.valid && phy_match
		&& mgmt_req.register_number <= `PRV_REG_LAST;

	assign adv_we[0] = mgmt_hit && mgmt_req.write && !phy_sel
		&& mgmt_req.register_number == `PRV_REG_ADVERT;
	assign adv_we[1] = mgmt_hit && mgmt_req.write && phy_sel
		&& mgmt_req.register_number == `PRV_REG_ADVERT;

	// ------------------------------------------------------------------------
	// Management read data
	// ------------------------------------------------------------------------
	always_comb begin
		next_mgmt_rdata = 16'h0000;
		unique case (mgmt_req.register_number)
			`PRV_REG_ID_UPPER: begin
				next_mgmt_rdata = ID_UPPER;
			end
			`PRV_REG_ID_LOWER: begin
				next_mgmt_rdata = ID_LOWER;
			end
			`PRV_REG_ADVERT: begin
				next_mgmt_rdata[`PRV_ADV_PAUSE_BIT] = adv[phy_sel][4];
				next_mgmt_rdata[`PRV_ADV_LOW_BIT +: 4] = adv[phy_sel][3:0];
				next_mgmt_rdata[4:0] = `PRV_SELECTOR;
			end
			`PRV_REG_PARTNER: begin
				next_mgmt_rdata[`PRV_ADV_PAUSE_BIT] = partner[phy_sel][4];
				next_mgmt_rdata[`PRV_ADV_LOW_BIT +: 4] =
					partner[phy_sel][3:0];
			end
			default: begin
				next_mgmt_rdata = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_ack <= 1'b0;
			mgmt_rdata <= 16'h0000;
		end else begin
			mgmt_ack <= mgmt_hit;
			if (mgmt_hit && !mgmt_req.write) begin
				mgmt_rdata <= next_mgmt_rdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Byte address decode
	// ------------------------------------------------------------------------
	assign port_hi = byte_req.addr[7:4];
	assign port_idx = byte_req.addr[3:0];

	always_comb begin
		bank_we = 3'h0;
		if (byte_req.valid && byte_req.write
			&& port_idx <= `PRV_CTRL_LAST_IDX) begin
			for (int p = 0; p < 3; p++) begin
				if (port_hi == 4'(p + 1)) begin
					bank_we[p] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phy_address_reg <= `PRV_PHY_ADDRESS_RST;
		end else if (byte_req.valid && byte_req.write
			&& byte_req.addr == `PRV_ADDR_PHY_ADDRESS) begin
			phy_address_reg <= byte_req.wdata;
		end
	end

	// ------------------------------------------------------------------------
	// Port banks
	// ------------------------------------------------------------------------
	for (genvar g = 0; g < 3; g++) begin : g_bank
		prv_port_bank u_bank (
			.clk(clk),
			.rst_n(rst_n),
			.byte_we(bank_we[g]),
			.byte_idx(port_idx),
			.byte_wdata(byte_req.wdata),
			.adv_we(g < 2 ? adv_we[g % 2] : 1'b0),
			.adv_wdata({mgmt_req.wdata[`PRV_ADV_PAUSE_BIT],
				mgmt_req.wdata[`PRV_ADV_LOW_BIT +: 4]}),
			.status_in(port_status[g]),
			.rd_idx(port_idx),
			.rd_byte(rd_byte[g]),
			.adv(adv[g]),
			.partner(partner[g])
		);
	end

	assign adv_flags[0] = adv[0];
	assign adv_flags[1] = adv[1];

	// ------------------------------------------------------------------------
	// Byte read data
	// ------------------------------------------------------------------------
	// eight bit answers
	always_comb begin
		next_byte_rdata = 8'h00;
		if (byte_req.addr == `PRV_ADDR_PHY_ADDRESS) begin
			next_byte_rdata = phy_address_reg;
		end else if (port_hi >= `PRV_PORT_FIRST_HI
			&& port_hi <= `PRV_PORT_LAST_HI) begin
			next_byte_rdata = rd_byte[2'(port_hi - 4'h1)];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_ack <= 1'b0;
			byte_rdata <= 8'h00;
		end else begin
			byte_ack <= byte_req.valid;
			if (byte_req.valid && !byte_req.write) begin
				byte_rdata <= next_byte_rdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_mgmt_read(logic [4:0] pa, logic [4:0] rn);
		mgmt_req.valid && !mgmt_req.write && !center_mode
			&& mgmt_req.phy_address == pa
			&& mgmt_req.register_number == rn;
	endsequence

	sequence s_adv_write(logic [4:0] pa);
		mgmt_req.valid && mgmt_req.write && !center_mode
			&& mgmt_req.phy_address == pa
			&& mgmt_req.register_number == `PRV_REG_ADVERT
			&& !(byte_req.valid && byte_req.write);
	endsequence

	a_id_upper_read: assert property (
		s_mgmt_read(`PRV_PHY_ADDRESS_FIRST, `PRV_REG_ID_UPPER)
		|=> mgmt_ack && mgmt_rdata == ID_UPPER)
		else $error("upper identifier read wrong");

	a_id_lower_read: assert property (
		s_mgmt_read(`PRV_PHY_ADDRESS_SECOND, `PRV_REG_ID_LOWER)
		|=> mgmt_ack && mgmt_rdata == ID_LOWER)
		else $error("lower identifier read wrong");

	a_adv_write_shared: assert property (
		s_adv_write(`PRV_PHY_ADDRESS_FIRST)
		|=> adv_flags[0] == $past({mgmt_req.wdata[10], mgmt_req.wdata[8:5]}))
		else $error("advert write not stored in shared byte");

	a_adv_second_phy: assert property (
		s_adv_write(`PRV_PHY_ADDRESS_SECOND)
		##1 !(mgmt_req.valid || (byte_req.valid && byte_req.write))
		##1 s_mgmt_read(`PRV_PHY_ADDRESS_SECOND, `PRV_REG_ADVERT)
		|=> mgmt_rdata[10:5] == {$past(mgmt_req.wdata[10], 3), 1'b0,
		$past(mgmt_req.wdata[8:5], 3)})
		else $error("second advert word does not match the write");

	a_adv_fixed_bits: assert property (
		mgmt_ack && $past(mgmt_req.register_number) == `PRV_REG_ADVERT
		&& !$past(mgmt_req.write) |-> mgmt_rdata[4:0] == 5'h01
		&& mgmt_rdata[15:11] == 5'h00 && !mgmt_rdata[9])
		else $error("advert fixed bits wrong");

	a_partner_mirror: assert property (
		s_mgmt_read(`PRV_PHY_ADDRESS_FIRST, `PRV_REG_PARTNER)
		|=> mgmt_rdata == {5'h00, $past(partner[0][4]), 1'b0,
		$past(partner[0][3:0]), 5'h00})
		else $error("partner word does not mirror status byte");

	a_unserved_reg: assert property (
		mgmt_req.valid && mgmt_req.register_number > 5'h05 |=> !mgmt_ack)
		else $error("unsupported register was answered");

	a_center_single: assert property (
		mgmt_req.valid && center_mode
		&& mgmt_req.phy_address != phy_address_reg[4:0] |=> !mgmt_ack)
		else $error("center mode answered a foreign address");

	a_byte_adv_shared: assert property (
		byte_req.valid && byte_req.write && byte_req.addr == 8'h1c
		|=> ##1 adv_flags[0] == $past(byte_req.wdata[4:0], 2)
		|| $past(adv_we[0], 2))
		else $error("port byte 28 write not shared with advert");

	a_status_first: assert property (
		byte_req.valid && !byte_req.write && byte_req.addr == 8'h1e
		|=> byte_ack && byte_rdata == $past(port_status[0][7:0], 2))
		else $error("first port status byte does not mirror input");

	a_status_second: assert property (
		byte_req.valid && !byte_req.write && byte_req.addr == 8'h2f
		|=> byte_ack && byte_rdata == $past(port_status[1][15:8], 2))
		else $error("second port status byte does not mirror input");

	a_status_third: assert property (
		byte_req.valid && !byte_req.write && byte_req.addr == 8'h3e
		|=> byte_ack && byte_rdata == $past(port_status[2][7:0], 2))
		else $error("third port status byte does not mirror input");

	a_byte_ack_every: assert property (
		byte_req.valid |=> byte_ack)
		else $error("byte request was not answered");

	a_served_ack: assert property (
		mgmt_req.valid && !center_mode
		&& (mgmt_req.phy_address == `PRV_PHY_ADDRESS_FIRST
		|| mgmt_req.phy_address == `PRV_PHY_ADDRESS_SECOND)
		&& mgmt_req.register_number <= `PRV_REG_LAST |=> mgmt_ack)
		else $error("served register was not answered");

endmodule : prv_phy_reg_view

// ===== tb/prv_host_model.sv
`timescale 1ns/1ns

module prv_host_model (
	// Clock
	input wire logic clk,
	// Management word side
	output prv_pkg::prv_mgmt_req_s mgmt_req,
	input wire logic mgmt_ack,
	input wire logic [15:0] mgmt_rdata,
	// Byte side
	output prv_pkg::prv_byte_req_s byte_req,
	input wire logic byte_ack,
	input wire logic [7:0] byte_rdata
);
	import prv_pkg::*;

	initial begin
		mgmt_req = '0;
		byte_req = '0;
	end

	// ------------------------------------------------------------
	// Word access
	// ------------------------------------------------------------
	// station picks address
	task automatic mgmt_acc(input logic w, input logic [4:0] pa,
		input logic [4:0] rn, input logic [15:0] wd,
		output logic ack, output logic [15:0] rd);
		@(posedge clk);
		mgmt_req <= {1'b1, w, pa, rn, wd};
		@(posedge clk);
		// Released fields flip so stale values never look valid
		mgmt_req <= {1'b0, ~w, ~pa, ~rn, ~wd};
		#1;
		ack = mgmt_ack;
		rd = mgmt_rdata;
	endtask : mgmt_acc

	// ------------------------------------------------------------
	// Byte access
	// ------------------------------------------------------------
	task automatic byte_acc(input logic w, input logic [7:0] a,
		input logic [7:0] wd, output logic ack, output logic [7:0] rd);
		@(posedge clk);
		byte_req <= {1'b1, w, a, wd};
		@(posedge clk);
		byte_req <= {1'b0, ~w, ~a, ~wd};
		#1;
		ack = byte_ack;
		rd = byte_rdata;
	endtask : byte_acc

endmodule : prv_host_model

// ===== tb/prv_phy_reg_view_tb.sv
`timescale 1ns/1ns

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
	$display("CHECK FAILED %s exp %h seen %h", n, e, g); \
	error_cnt++; end end

module prv_phy_reg_view_tb;
	import prv_pkg::*;

	localparam logic [15:0] ID_U = 16'h3c96;
	localparam logic [15:0] ID_L = 16'h69c3;

	logic clk;
	logic rst_n;
	logic center_mode;
	prv_mgmt_req_s mgmt_req;
	prv_byte_req_s byte_req;
	prv_status_t port_status;
	prv_adv_t adv_flags;
	logic mgmt_ack;
	logic byte_ack;
	logic [15:0] mgmt_rdata;
	logic [7:0] byte_rdata;
	int error_cnt = 0;
	int checks = 0;

	prv_phy_reg_view #(.ID_UPPER(ID_U), .ID_LOWER(ID_L))
		prv_phy_reg_view_inst (.clk(clk), .rst_n(rst_n),
		.mgmt_req(mgmt_req), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
		.byte_req(byte_req), .byte_ack(byte_ack), .byte_rdata(byte_rdata),
		.center_mode(center_mode), .port_status(port_status),
		.adv_flags(adv_flags));

	prv_host_model prv_host_model_inst (.clk(clk), .mgmt_req(mgmt_req),
		.mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
		.byte_req(byte_req), .byte_ack(byte_ack), .byte_rdata(byte_rdata));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic mchk(logic w, logic [4:0] pa, logic [4:0] rn,
		logic [15:0] wd, logic ea, logic [15:0] ed);
		logic a;
		logic [15:0] d;
		prv_host_model_inst.mgmt_acc(w, pa, rn, wd, a, d);
		`CHK("mgmt_ack", ea, a)
		if (ea && !w) `CHK("mgmt_rdata", ed, d)
	endtask : mchk

	task automatic bchk(logic w, logic [7:0] ad, logic [7:0] wd,
		logic [7:0] ed);
		logic a;
		logic [7:0] d;
		prv_host_model_inst.byte_acc(w, ad, wd, a, d);
		`CHK("byte_ack", 1'b1, a)
		if (!w) `CHK("byte_rdata", ed, d)
	endtask : bchk

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_ident;
		mchk(1'b0, 5'h01, 5'h02, 16'h0000, 1'b1, ID_U);
		mchk(1'b1, 5'h01, 5'h02, 16'hffff, 1'b1, 16'h0000);
		mchk(1'b0, 5'h02, 5'h02, 16'h0000, 1'b1, ID_U);
		mchk(1'b1, 5'h02, 5'h03, 16'h0000, 1'b1, 16'h0000);
		mchk(1'b0, 5'h02, 5'h03, 16'h0000, 1'b1, ID_L);
		mchk(1'b0, 5'h02, 5'h00, 16'h0000, 1'b1, 16'h0000);
		mchk(1'b0, 5'h01, 5'h06, 16'h0000, 1'b0, 16'h0000);
		mchk(1'b0, 5'h03, 5'h02, 16'h0000, 1'b0, 16'h0000);
		mchk(1'b1, 5'h00, 5'h04, 16'h0000, 1'b0, 16'h0000);
		mchk(1'b0, 5'h01, 5'h05, 16'h0000, 1'b1, 16'h0000);
	endtask : t_ident

	task automatic t_adv;
		bchk(1'b0, 8'h1c, 8'h00, 8'h1f);
		bchk(1'b0, 8'h2c, 8'h00, 8'h1f);
		mchk(1'b0, 5'h01, 5'h04, 16'h0000, 1'b1, 16'h05e1);
		mchk(1'b1, 5'h02, 5'h04, 16'h0000, 1'b1, 16'h0000);
		mchk(1'b0, 5'h02, 5'h04, 16'h0000, 1'b1, 16'h0001);
		bchk(1'b0, 8'h2c, 8'h00, 8'h00);
		`CHK("adv_flags", 10'h01f, adv_flags)
		mchk(1'b1, 5'h02, 5'h04, 16'hffff, 1'b1, 16'h0000);
		mchk(1'b0, 5'h02, 5'h04, 16'h0000, 1'b1, 16'h05e1);
		bchk(1'b1, 8'h1c, 8'h15, 8'h00);
		mchk(1'b0, 5'h01, 5'h04, 16'h0000, 1'b1, 16'h04a1);
		bchk(1'b1, 8'h2c, 8'h0a, 8'h00);
		mchk(1'b0, 5'h02, 5'h04, 16'h0000, 1'b1, 16'h0141);
	endtask : t_adv

	task automatic t_partner;
		@(posedge clk);
		port_status <= {16'h3cc3, 16'ha515, 16'h5aea};
		repeat (2) @(posedge clk);
		mchk(1'b0, 5'h01, 5'h05, 16'h0000, 1'b1, 16'h0140);
		mchk(1'b0, 5'h02, 5'h05, 16'h0000, 1'b1, 16'h04a0);
		mchk(1'b1, 5'h01, 5'h05, 16'hffff, 1'b1, 16'h0000);
		mchk(1'b0, 5'h01, 5'h05, 16'h0000, 1'b1, 16'h0140);
		bchk(1'b0, 8'h1e, 8'h00, 8'hea);
		bchk(1'b0, 8'h1f, 8'h00, 8'h5a);
		bchk(1'b0, 8'h2f, 8'h00, 8'ha5);
		bchk(1'b1, 8'h3e, 8'h00, 8'h00);
		bchk(1'b0, 8'h3e, 8'h00, 8'hc3);
		bchk(1'b0, 8'h3f, 8'h00, 8'h3c);
	endtask : t_partner

	task automatic t_ctrl;
		logic [7:0] tbl [6] = '{8'h10, 8'h1d, 8'h20, 8'h2d, 8'h30, 8'h3d};
		foreach (tbl[i]) begin
			bchk(1'b1, tbl[i], tbl[i] ^ 8'h5a, 8'h00);
			bchk(1'b0, tbl[i], 8'h00, tbl[i] ^ 8'h5a);
		end
		bchk(1'b1, 8'h0f, 8'hff, 8'h00);
		bchk(1'b0, 8'h0f, 8'h00, 8'h00);
		bchk(1'b1, 8'h4f, 8'hff, 8'h00);
		bchk(1'b0, 8'h4f, 8'h00, 8'h00);
	endtask : t_ctrl

	task automatic t_center;
		bchk(1'b0, 8'h40, 8'h00, 8'h01);
		@(posedge clk);
		center_mode <= 1'b1;
		bchk(1'b1, 8'h40, 8'h07, 8'h00);
		mchk(1'b0, 5'h07, 5'h02, 16'h0000, 1'b1, ID_U);
		mchk(1'b0, 5'h01, 5'h02, 16'h0000, 1'b0, 16'h0000);
		mchk(1'b0, 5'h02, 5'h02, 16'h0000, 1'b0, 16'h0000);
		mchk(1'b1, 5'h07, 5'h04, 16'h0000, 1'b1, 16'h0000);
		`CHK("adv_flags", 10'h140, adv_flags)
	endtask : t_center

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		center_mode = 1'b0;
		port_status = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_ident();
		t_adv();
		t_partner();
		t_ctrl();
		t_center();
		finish_test();
	end

endmodule : prv_phy_reg_view_tb
